// File: fbxm_consts.vh
// constants for the fieldbus exchange memory
`ifndef FBXM_CONSTS_VH
`define FBXM_CONSTS_VH
`define FBXM_AREA_BYTES   1536
`define FBXM_ADDR_W       11
`define FBXM_REG_W        10
`define FBXM_BANK_WORDS   768
`define FBXM_STAT_OFS     11'h600
`define FBXM_MAP_OFS      11'h602
`define FBXM_MAP_END_OFS  11'h611
`define FBXM_CTRL_OFS     11'h600
`define FBXM_STAT_REG     10'h300
`define FBXM_MAP_REG      10'h301
`define FBXM_MAP_LAST_REG 10'h308
`define FBXM_CTRL_REG     10'h300
`define FBXM_MODE_W       2
`define FBXM_MODE_OFFLINE 2'h0
`define FBXM_MODE_STOP    2'h1
`define FBXM_MODE_CLEAR   2'h2
`define FBXM_MODE_OPERATE 2'h3
`define FBXM_CTRL_RST     2'h1
`define FBXM_SLAVES       126
`define FBXM_MAP_BITS     128
`define FBXM_RSP_W        18
`define FBXM_RSP_DEPTH    32
`define FBXM_AREA_IN      1'b0
`define FBXM_AREA_OUT     1'b1
`endif

// File: fbxm_exchange.v
// fieldbus exchange memory with tcp-side response fifo
`include "fbxm_consts.vh"

module fbxm_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // pointer step with wrap, shared by both ends
  function [AW-1:0] next_ptr;
    input [AW-1:0] p;
    begin
      next_ptr = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // count is one bit wider than the pointers so that full and empty differ
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge mclk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (pop)
      begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // fbxm_fifo

// Function
// - separate input and output areas, 1536 data bytes each, offsets 0 to 1535
// - input area flows fieldbus to tcp; output area flows tcp to fieldbus
// - input offsets 1536-1553 are status; word 1536 bits 1:0 give master mode
// - offsets 1538-1553 are slave bitmap, eight slaves per byte, slaves 0 to 125
// - bitmap bit is one while its slave is in data exchange, else zero
// - output word 1536 bits 1:0 command master mode; code 00 is never taken
// - received data from either side is stored into the exchange memory
// - fieldbus output modules fetch bytes from their output-area offset
// - fieldbus side addresses the memory in byte units
// - tcp read commands take outgoing data from the exchange memory
// - fieldbus input writes land at once so tcp reads see latest values
// - one tcp register equals two consecutive bytes, even byte high
module fbxm_exchange #(
  parameter RSP_DEPTH = 32,
  parameter RSP_AW    = 5
) (
  input  wire                          mclk_i,
  input  wire                          rst_i,
  input  wire                          fb_in_we_i,
  input  wire [`FBXM_ADDR_W-1:0]       fb_in_addr_i,
  input  wire [7:0]                    fb_in_data_i,
  input  wire                          fb_out_re_i,
  input  wire [`FBXM_ADDR_W-1:0]       fb_out_addr_i,
  output reg  [7:0]                    fb_out_data_o,
  output reg                           fb_out_valid_o,
  input  wire [`FBXM_MODE_W-1:0]       fb_master_mode_i,
  input  wire [`FBXM_SLAVES-1:0]       fb_slave_exch_i,
  output wire [`FBXM_MODE_W-1:0]       master_cmd_o,
  input  wire                          tcp_req_valid_i,
  output wire                          tcp_req_ready_o,
  input  wire                          tcp_req_write_i,
  input  wire                          tcp_req_area_i,
  input  wire [`FBXM_REG_W-1:0]        tcp_req_reg_i,
  input  wire [15:0]                   tcp_req_wdata_i,
  output wire                          tcp_rsp_valid_o,
  input  wire                          tcp_rsp_ready_i,
  output wire [15:0]                   tcp_rsp_data_o,
  output wire                          tcp_rsp_write_o,
  output wire                          tcp_rsp_err_o
);
  // each area is split in even and odd byte banks so a tcp word is one access
  reg [7:0]                 in_hi_mem  [0:`FBXM_BANK_WORDS-1];
  reg [7:0]                 in_lo_mem  [0:`FBXM_BANK_WORDS-1];
  reg [7:0]                 out_hi_mem [0:`FBXM_BANK_WORDS-1];
  reg [7:0]                 out_lo_mem [0:`FBXM_BANK_WORDS-1];
  reg [`FBXM_MODE_W-1:0]    mode_reg;
  reg [`FBXM_MAP_BITS-1:0]  map_reg;
  reg [`FBXM_MODE_W-1:0]    cmd_reg;
  reg                       pend_reg;
  reg [`FBXM_RSP_W-1:0]     rsp_reg;
  reg [`FBXM_RSP_W-1:0]     rsp_next;
  wire                      fifo_in_ready;
  wire                      accept;
  wire [`FBXM_RSP_W-1:0]    fifo_out;
  wire                      in_data_reg;
  wire                      map_hit;
  wire [2:0]                map_idx;
  wire [9:0]                word_idx;
  wire                      out_wr;

  function in_data_byte;
    input [`FBXM_ADDR_W-1:0] a;
    begin
      in_data_byte = (a < `FBXM_STAT_OFS);
    end
  endfunction

  function [7:0] map_byte;
    input [`FBXM_MAP_BITS-1:0] m;
    input [3:0]                k;
    begin
      map_byte = m[{k, 3'b000} +: 8];
    end
  endfunction

  // code 00 is reserved in the control word and never reaches the master
  function legal_cmd;
    input [`FBXM_MODE_W-1:0] c;
    begin
      legal_cmd = (c != `FBXM_MODE_OFFLINE);
    end
  endfunction

  assign master_cmd_o    = cmd_reg;
  assign word_idx        = tcp_req_reg_i;
  assign in_data_reg     = in_data_byte({tcp_req_reg_i, 1'b0});
  assign map_hit         = (tcp_req_reg_i >= `FBXM_MAP_REG) &&
                           (tcp_req_reg_i <= `FBXM_MAP_LAST_REG);
  // registers 769..776 give bitmap words 0..7, so the low three bits minus one
  assign map_idx         = tcp_req_reg_i[2:0] - 3'h1;
  // a held response may leave while a new request enters the stage
  assign tcp_req_ready_o = !pend_reg || fifo_in_ready;
  assign accept          = tcp_req_valid_i && tcp_req_ready_o;
  assign out_wr          = accept && tcp_req_write_i &&
                           (tcp_req_area_i == `FBXM_AREA_OUT);
  assign tcp_rsp_err_o   = fifo_out[17];
  assign tcp_rsp_write_o = fifo_out[16];
  assign tcp_rsp_data_o  = fifo_out[15:0];

  // fieldbus side: byte addressed input refresh, visible next cycle
  // offsets at or above the status word are dropped; status belongs to the master
  always @(posedge mclk_i)
  begin
    if (fb_in_we_i && in_data_byte(fb_in_addr_i))
    begin
      if (fb_in_addr_i[0])
      begin
        in_lo_mem[fb_in_addr_i[10:1]] <= fb_in_data_i;
      end
      else
      begin
        in_hi_mem[fb_in_addr_i[10:1]] <= fb_in_data_i;
      end
    end
  end

  // tcp side: register writes reach only the output data area
  always @(posedge mclk_i)
  begin
    if (out_wr && in_data_reg)
    begin
      out_hi_mem[word_idx] <= tcp_req_wdata_i[15:8];
      out_lo_mem[word_idx] <= tcp_req_wdata_i[7:0];
    end
  end

  // status follows the fieldbus master logic every cycle
  // the one-cycle lag keeps the wide bitmap off the tcp read path
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      mode_reg <= `FBXM_MODE_OFFLINE;
      map_reg  <= {`FBXM_MAP_BITS{1'b0}};
    end
    else
    begin
      mode_reg <= fb_master_mode_i;
      map_reg  <= {2'b00, fb_slave_exch_i};
    end
  end

  // control word; a reserved code would leave the master undefined, so it is dropped
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cmd_reg <= `FBXM_CTRL_RST;
    end
    else if (out_wr && tcp_req_reg_i == `FBXM_CTRL_REG &&
             legal_cmd(tcp_req_wdata_i[1:0]))
    begin
      cmd_reg <= tcp_req_wdata_i[1:0];
    end
  end

  // fieldbus output fetch, one cycle latency
  // addresses past the data area read zero rather than the control word
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      fb_out_data_o  <= 8'h00;
      fb_out_valid_o <= 1'b0;
    end
    else
    begin
      fb_out_valid_o <= fb_out_re_i;
      if (fb_out_re_i)
      begin
        if (!in_data_byte(fb_out_addr_i))
        begin
          fb_out_data_o <= 8'h00;
        end
        else if (fb_out_addr_i[0])
        begin
          fb_out_data_o <= out_lo_mem[fb_out_addr_i[10:1]];
        end
        else
        begin
          fb_out_data_o <= out_hi_mem[fb_out_addr_i[10:1]];
        end
      end
    end
  end

  // response word: {err, write, data}
  always @*
  begin
    rsp_next = {1'b1, tcp_req_write_i, 16'h0000};
    if (tcp_req_area_i == `FBXM_AREA_IN)
    begin
      if (tcp_req_write_i)
      begin
        rsp_next = {1'b1, 1'b1, 16'h0000};
      end
      else if (in_data_reg)
      begin
        rsp_next = {1'b0, 1'b0, in_hi_mem[word_idx], in_lo_mem[word_idx]};
      end
      else if (tcp_req_reg_i == `FBXM_STAT_REG)
      begin
        rsp_next = {1'b0, 1'b0, 14'h0000, mode_reg};
      end
      else if (map_hit)
      begin
        rsp_next = {1'b0, 1'b0, map_byte(map_reg, {map_idx, 1'b0}),
                    map_byte(map_reg, {map_idx, 1'b1})};
      end
    end
    else
    begin
      if (in_data_reg)
      begin
        rsp_next = tcp_req_write_i ? {1'b0, 1'b1, 16'h0000} :
                   {1'b0, 1'b0, out_hi_mem[word_idx], out_lo_mem[word_idx]};
      end
      else if (tcp_req_reg_i == `FBXM_CTRL_REG)
      begin
        rsp_next = tcp_req_write_i ?
                   {!legal_cmd(tcp_req_wdata_i[1:0]), 1'b1, 16'h0000} :
                   {1'b0, 1'b0, 14'h0000, cmd_reg};
      end
    end
  end

  // one staged slot lets ready stay high while the fifo takes the previous answer
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pend_reg <= 1'b0;
      rsp_reg  <= {`FBXM_RSP_W{1'b0}};
    end
    else
    begin
      if (accept)
      begin
        pend_reg <= 1'b1;
        rsp_reg  <= rsp_next;
      end
      else if (fifo_in_ready)
      begin
        pend_reg <= 1'b0;
      end
    end
  end

  fbxm_fifo #(
    .WIDTH (`FBXM_RSP_W),
    .DEPTH (RSP_DEPTH),
    .AW    (RSP_AW)
  ) u_rsp_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pend_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rsp_reg),
    .out_valid_o (tcp_rsp_valid_o),
    .out_ready_i (tcp_rsp_ready_i),
    .out_data_o  (fifo_out)
  );
endmodule // fbxm_exchange

// File: fbxm_exchange_checker.sv
// port assertions for the exchange memory
`include "fbxm_consts.vh"
module fbxm_exchange_checker (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        fb_out_re_i,
  input wire logic [10:0] fb_out_addr_i,
  input wire logic [7:0]  fb_out_data_o,
  input wire logic        fb_out_valid_o,
  input wire logic [1:0]  master_cmd_o,
  input wire logic        tcp_req_valid_i,
  input wire logic        tcp_req_ready_o,
  input wire logic        tcp_req_write_i,
  input wire logic        tcp_req_area_i,
  input wire logic [9:0]  tcp_req_reg_i,
  input wire logic [15:0] tcp_req_wdata_i,
  input wire logic        tcp_rsp_valid_o,
  input wire logic        tcp_rsp_ready_i,
  input wire logic [15:0] tcp_rsp_data_o,
  input wire logic        tcp_rsp_write_o,
  input wire logic        tcp_rsp_err_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire cw = tcp_req_valid_i && tcp_req_ready_o && tcp_req_write_i && tcp_req_area_i
            && tcp_req_reg_i == `FBXM_CTRL_REG;
  logic [1:0] cmd_exp;
  always @(posedge mclk_i)
    if (cw)
      cmd_exp <= tcp_req_wdata_i[1:0];
  AST_RD_VALID: assert property (fb_out_re_i |=> fb_out_valid_o) else $error("no read valid");
  AST_VALID_PULSE: assert property (!fb_out_re_i |=> !fb_out_valid_o)
    else $error("stray read valid");
  AST_RD_HIGH: assert property (fb_out_re_i && fb_out_addr_i >= 11'h0600 |=> fb_out_data_o == 0)
    else $error("read past area not zero");
  AST_CMD_LEGAL: assert property (master_cmd_o != 2'h0) else $error("reserved command");
  AST_CMD_WRITE: assert property (cw && tcp_req_wdata_i[1:0] != 0 |=> ##[0:1] master_cmd_o == cmd_exp)
    else $error("command not taken");
  AST_CMD_RSV: assert property (cw && tcp_req_wdata_i[1:0] == 0 |=> $stable(master_cmd_o) [*2])
    else $error("reserved code changed command");
  AST_RSP_LAT: assert property (tcp_req_valid_i && tcp_req_ready_o && !tcp_rsp_valid_o
    |-> ##[1:2] tcp_rsp_valid_o) else $error("response late");
  AST_RSP_HOLD: assert property (tcp_rsp_valid_o && !tcp_rsp_ready_i
    |=> tcp_rsp_valid_o && $stable(tcp_rsp_data_o)) else $error("response dropped");
  AST_ZERO_DATA: assert property (tcp_rsp_valid_o && (tcp_rsp_write_o || tcp_rsp_err_o)
    |-> tcp_rsp_data_o == 0) else $error("data on write or error");
  AST_RDY: assert property (!tcp_rsp_valid_o |-> tcp_req_ready_o) else $error("refused when empty");
endmodule // fbxm_exchange_checker
bind fbxm_exchange fbxm_exchange_checker i_fbxm_exchange_checker (.mclk_i, .rst_i, .fb_out_re_i,
  .fb_out_addr_i, .fb_out_data_o, .fb_out_valid_o, .master_cmd_o, .tcp_req_valid_i,
  .tcp_req_ready_o, .tcp_req_write_i, .tcp_req_area_i, .tcp_req_reg_i, .tcp_req_wdata_i,
  .tcp_rsp_valid_o, .tcp_rsp_ready_i, .tcp_rsp_data_o, .tcp_rsp_write_o, .tcp_rsp_err_o);

// File: fbxm_fb_model.sv
// behavioural fieldbus master and its slave stations
module fbxm_fb_model (
  input  wire logic         mclk_i,
  input  wire logic         set_i,
  input  wire logic [1:0]   mode_i,
  input  wire logic [125:0] exch_i,
  output logic      [1:0]   mode_o,
  output logic      [125:0] exch_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial mode_o = 2'h0;
  initial exch_o = 126'h0;
  // state only moves on an edge, as a master reports a settled cycle
  always @(posedge mclk_i)
    if (set_i)
    begin
      mode_o <= mode_i;
      exch_o <= exch_i;
    end
endmodule // fbxm_fb_model

// File: test_fbxm_exchange.sv
// self-checking bench for the exchange memory
module test_fbxm_exchange;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_i = 1, fb_in_we_i = 0, fb_out_re_i = 0, set = 0, e, wr;
  logic tcp_req_valid_i = 0, tcp_req_write_i = 0, tcp_req_area_i = 0, tcp_rsp_ready_i = 1;
  logic [10:0] fb_in_addr_i = 0, fb_out_addr_i = 0;
  logic [7:0] fb_in_data_i = 0, mem [0:79];
  logic [9:0] tcp_req_reg_i = 0;
  logic [15:0] tcp_req_wdata_i = 0, q, w16;
  logic [1:0] mode_set = 0;
  logic [125:0] exch_set = 0;
  wire [7:0] fb_out_data_o;
  wire [1:0] master_cmd_o, fb_mode;
  wire [15:0] tcp_rsp_data_o;
  wire [125:0] fb_exch;
  wire fb_out_valid_o, tcp_req_ready_o, tcp_rsp_valid_o, tcp_rsp_write_o, tcp_rsp_err_o;
  integer num_errors = 0, n_checks = 0, seed = 72, i, j, k, n;
  fbxm_exchange i_fbxm_exchange (.mclk_i, .rst_i, .fb_in_we_i, .fb_in_addr_i, .fb_in_data_i,
    .fb_out_re_i, .fb_out_addr_i, .fb_out_data_o, .fb_out_valid_o, .fb_master_mode_i(fb_mode),
    .fb_slave_exch_i(fb_exch), .master_cmd_o, .tcp_req_valid_i, .tcp_req_ready_o,
    .tcp_req_write_i, .tcp_req_area_i, .tcp_req_reg_i, .tcp_req_wdata_i, .tcp_rsp_valid_o,
    .tcp_rsp_ready_i, .tcp_rsp_data_o, .tcp_rsp_write_o, .tcp_rsp_err_o);
  fbxm_fb_model i_fbxm_fb_model (.mclk_i, .set_i(set), .mode_i(mode_set), .exch_i(exch_set),
    .mode_o(fb_mode), .exch_o(fb_exch));
  initial forever #20 mclk_i = ~mclk_i;
  task complete_run;
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] x);
    n_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task bail;
    num_errors++;
    complete_run;
  endtask
  // request held until ready is seen high at a falling edge, then dropped after the next rising edge
  task send(input w, input a, input [9:0] r, input [15:0] d);
    tcp_req_valid_i <= 1; tcp_req_write_i <= w; tcp_req_area_i <= a;
    tcp_req_reg_i <= r; tcp_req_wdata_i <= d; k = 0;
    @(negedge mclk_i);
    while (tcp_req_ready_o !== 1)
    begin
      if (++k > 99) bail;
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    tcp_req_valid_i <= 0;
  endtask
  task recv;
    k = 0;
    @(negedge mclk_i);
    while (tcp_rsp_valid_o !== 1)
    begin
      if (++k > 99) bail;
      @(negedge mclk_i);
    end
    q = tcp_rsp_data_o; e = tcp_rsp_err_o;
    wr = tcp_rsp_write_o;
    @(posedge mclk_i);
  endtask
  task tcp(input w, input a, input [9:0] r, input [15:0] d);
    send(w, a, r, d);
    recv;
  endtask
  task rd_fb(input [10:0] ad, input [7:0] x);
    fb_out_re_i <= 1; fb_out_addr_i <= ad;
    @(posedge mclk_i);
    fb_out_re_i <= 0;
    @(negedge mclk_i);
    chk({fb_out_valid_o, fb_out_data_o}, {1'b1, x});
    @(posedge mclk_i);
  endtask
  // bitmap register j: high byte slaves 16j..16j+7, low byte the next eight
  function automatic [15:0] exp_map(input integer jj);
    logic [127:0] m;
    m = {2'b00, exch_set};
    return {m[16*jj +: 8], m[16*jj+8 +: 8]};
  endfunction
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 0;
    @(posedge mclk_i);
    chk(master_cmd_o, 16'h0001);
    for (i = 0; i < 81; i++)
    begin
      if (i < 80) mem[i] = $random(seed);
      fb_in_we_i <= 1;
      fb_in_addr_i <= (i == 80) ? 11'h0600 : (i < 78) ? i : i + 1456;
      fb_in_data_i <= (i == 80) ? 8'hff : mem[i];
      @(posedge mclk_i);
    end
    fb_in_we_i <= 0;
    for (i = 0; i < 40; i++)
    begin
      tcp(0, 0, (i < 39) ? i : 767, 16'h0000);
      chk(q, {mem[2*i], mem[2*i+1]});
    end
    for (i = 0; i < 4; i++)
    begin
      mode_set <= i; set <= 1;
      exch_set <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      @(posedge mclk_i);
      set <= 0;
      tcp(1, 0, 10'h0300, 16'h0003);
      chk({wr, e}, 16'h0003);
      tcp(0, 0, 10'h0300, 16'h0000);
      chk(q, i);
      for (j = 0; j < 8; j++)
      begin
        tcp(0, 0, 10'h0301 + j, 16'h0000);
        chk(q, exp_map(j));
      end
    end
    for (i = 3; i >= 0; i--)
    begin
      tcp(1, 1, 10'h0300, i);
      chk({wr, e}, {1'b1, i == 0});
      tcp(0, 1, 10'h0300, 16'h0000);
      chk(q, (i == 0) ? 1 : i);
      chk(master_cmd_o, (i == 0) ? 1 : i);
    end
    w16 = $random(seed);
    tcp(1, 1, 10'h02ff, w16);
    rd_fb(11'h05fe, w16[15:8]);
    rd_fb(11'h05ff, w16[7:0]);
    rd_fb(11'h0600, 8'h00);
    tcp(0, 1, 10'h0301, 16'h0000);
    chk({wr, e}, 16'h0001);
    tcp(0, 1, 10'h02ff, 16'h0000);
    chk(q, w16);
    // consumer stalls: fill the response buffer until it refuses
    tcp_rsp_ready_i <= 0; tcp_req_valid_i <= 1; tcp_req_write_i <= 0; tcp_req_area_i <= 0;
    for (n = 0; n < 40; n++)
    begin
      tcp_req_reg_i <= n;
      @(negedge mclk_i);
      if (tcp_req_ready_o !== 1) break;
      @(posedge mclk_i);
    end
    @(posedge mclk_i);
    tcp_req_valid_i <= 0; tcp_rsp_ready_i <= 1;
    chk(n, 33);
    for (j = 0; j < n; j++)
    begin
      recv;
      chk(q, {mem[2*j], mem[2*j+1]});
    end
    complete_run;
  end
endmodule // test_fbxm_exchange
